// ### design/prpwm_pkg.sv
// Types shared by the pseudo-random PWM block
package prpwm_pkg;

	// Last member is bit 0, so run sits at the bottom of the control word
	typedef struct packed {
		logic sw_kill;
		logic invert;
		logic stop_on_kill;
		logic run;
	} ctrl_type;

	typedef struct packed {
		logic terminal_count_event;
		logic compare_b_hit;
		logic compare_a_hit;
	} event_type;

	typedef enum logic [1:0] {
		AXI_IDLE = 2'b00,
		AXI_RESP = 2'b01
	} axi_state_type;

endpackage : prpwm_pkg

// ### design/prpwm_regs.svh
// Register offsets, field positions and reset values of the pseudo-random PWM block
`ifndef PRPWM_REGS_SVH
`define PRPWM_REGS_SVH

`define PRPWM_CTRL_OFFS      12'h000
`define PRPWM_COUNTER_OFFS   12'h004
`define PRPWM_PERIOD_OFFS    12'h008
`define PRPWM_TAP_MASK_OFFS  12'h00c
`define PRPWM_CMP_A_OFFS     12'h010
`define PRPWM_CMP_B_OFFS     12'h014
`define PRPWM_STATUS_OFFS    12'h018
`define PRPWM_INT_STAT_OFFS  12'h01c
`define PRPWM_INT_MASK_OFFS  12'h020

`define PRPWM_CTRL_RUN_BIT   0
`define PRPWM_CTRL_STOPK_BIT 1
`define PRPWM_CTRL_INV_BIT   2
`define PRPWM_CTRL_KILL_BIT  3

`define PRPWM_INT_TC_BIT     0
`define PRPWM_INT_CMPA_BIT   1
`define PRPWM_INT_CMPB_BIT   2

`define PRPWM_TAP_MASK_RST   32'h0000_002d
`define PRPWM_WORD_RST       32'h0000_0000
`define PRPWM_PRESCALE_RST   8'h00

`endif

// ### design/pseudo_random_pwm_lfsr.sv
// Pseudo-random PWM generator with LFSR counter and AXI4-Lite registers
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "prpwm_regs.svh"

// Summary of operation
// - Drive a line output and a complementary line output from one compare result.
// - Counter steps as an LFSR with taps from the tap mask register.
// - 16-bit: feedback is XOR of masked bits, shift right, insert at bit 15.
// - 32-bit: shift right one, XOR of masked bits enters bit 31.
// - Max-length 16-bit taps are counter bits 5, 3, 2 and 0.
// - 8-bit LFSR in upper byte uses bits 12, 11, 10 and 8.
// - Max-length 32-bit taps are counter bits 7, 6, 2 and 0.
// - Seed 0xace1 with 16-bit taps steps 0xace1, 0x5670, repeats after 65535.
// - Shorter n-bit LFSR in upper bits gives period 2^n-1; tap t is bit 16-t.
// - Any tap mask is accepted and yields its own period.
// - Line high when low counter bits are below the compare value.
// - Terminal count on counter equal period, compare hits on equal compare values.
// - Control bit 2 (invert) inverts the line polarity.
// - Kill suppresses both outputs while it lasts; with stop-on-kill it also stops the counter and clears run.
module pseudo_random_pwm_lfsr #(
	parameter int unsigned GROUP_COUNTER_WIDTH = 16
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        clk_en_i,
	input  wire logic        count_tick_i,
	input  wire logic        kill_i,
	input  wire logic [11:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [11:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             line_wave_out_o,
	output logic             inverse_wave_out_o,
	output logic             terminal_count_event_o,
	output logic             compare_a_hit_o,
	output logic             compare_b_hit_o,
	output logic             irq_o
);

	localparam int unsigned W = GROUP_COUNTER_WIDTH;

	// ==========================================================
	// Registers
	prpwm_pkg::ctrl_type      ctrl_r;
	logic [W-1:0]             counter_r;
	logic [W-1:0]             period_r;
	logic [W-1:0]             tap_mask_reg_r;
	logic [W-1:0]             compare_value_a_r;
	logic [W-1:0]             compare_value_b_r;
	logic [2:0]               int_stat_r;
	logic [2:0]               int_mask_r;
	prpwm_pkg::event_type     evt_nxt;
	prpwm_pkg::axi_state_type wr_state_r;
	logic                     aw_got_r;
	logic                     w_got_r;
	logic [11:0]              awaddr_r;
	logic [31:0]              wdata_r;
	logic [3:0]               wstrb_r;
	logic                     wr_fire;
	logic                     wr_ok;
	logic                     rd_ok;
	logic [31:0]              rd_word;
	logic                     step;
	logic                     feedback;
	logic                     killed;
	logic                     line_raw;
	logic                     line_nxt;

	function automatic logic [31:0] merge_word(input logic [31:0] old_w, input logic [31:0] new_w,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return res;
	endfunction : merge_word

	function automatic logic map_hit(input logic [11:0] addr);
		map_hit = (addr == `PRPWM_CTRL_OFFS) || (addr == `PRPWM_COUNTER_OFFS) ||
			(addr == `PRPWM_PERIOD_OFFS) || (addr == `PRPWM_TAP_MASK_OFFS) ||
			(addr == `PRPWM_CMP_A_OFFS) || (addr == `PRPWM_CMP_B_OFFS) ||
			(addr == `PRPWM_STATUS_OFFS) || (addr == `PRPWM_INT_STAT_OFFS) ||
			(addr == `PRPWM_INT_MASK_OFFS);
	endfunction : map_hit

	// ==========================================================
	// AXI4-Lite write channel
	assign s_axi_awready_o = (wr_state_r == prpwm_pkg::AXI_IDLE) && !aw_got_r;
	assign s_axi_wready_o  = (wr_state_r == prpwm_pkg::AXI_IDLE) && !w_got_r;
	assign wr_fire         = clk_en_i && (wr_state_r == prpwm_pkg::AXI_IDLE) &&
		(aw_got_r || s_axi_awvalid_i) && (w_got_r || s_axi_wvalid_i);
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	assign wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr_i;
	assign wr_data = w_got_r ? wdata_r : s_axi_wdata_i;
	assign wr_strb = w_got_r ? wstrb_r : s_axi_wstrb_i;
	assign wr_ok   = map_hit(wr_addr);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_state_r     <= prpwm_pkg::AXI_IDLE;
			aw_got_r       <= 1'b0;
			w_got_r        <= 1'b0;
			awaddr_r       <= 12'h000;
			wdata_r        <= `PRPWM_WORD_RST;
			wstrb_r        <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= 2'h0;
		end else if (clk_en_i) begin
			if (wr_fire) begin
				wr_state_r     <= prpwm_pkg::AXI_RESP;
				aw_got_r       <= 1'b0;
				w_got_r        <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_ok ? 2'h0 : 2'h2;
			end else if (wr_state_r == prpwm_pkg::AXI_IDLE) begin
				if (s_axi_awvalid_i && !aw_got_r) begin
					aw_got_r <= 1'b1;
					awaddr_r <= s_axi_awaddr_i;
				end
				if (s_axi_wvalid_i && !w_got_r) begin
					w_got_r <= 1'b1;
					wdata_r <= s_axi_wdata_i;
					wstrb_r <= s_axi_wstrb_i;
				end
			end else if (s_axi_bready_i) begin
				wr_state_r     <= prpwm_pkg::AXI_IDLE;
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_ok           = map_hit(s_axi_araddr_i);

	always_comb begin
		rd_word = `PRPWM_WORD_RST;
		if (s_axi_araddr_i == `PRPWM_CTRL_OFFS) begin
			rd_word[3:0] = ctrl_r;
		end else if (s_axi_araddr_i == `PRPWM_COUNTER_OFFS) begin
			rd_word[W-1:0] = counter_r;
		end else if (s_axi_araddr_i == `PRPWM_PERIOD_OFFS) begin
			rd_word[W-1:0] = period_r;
		end else if (s_axi_araddr_i == `PRPWM_TAP_MASK_OFFS) begin
			rd_word[W-1:0] = tap_mask_reg_r;
		end else if (s_axi_araddr_i == `PRPWM_CMP_A_OFFS) begin
			rd_word[W-1:0] = compare_value_a_r;
		end else if (s_axi_araddr_i == `PRPWM_CMP_B_OFFS) begin
			rd_word[W-1:0] = compare_value_b_r;
		end else if (s_axi_araddr_i == `PRPWM_STATUS_OFFS) begin
			rd_word[2:0] = {killed, line_wave_out_o, ctrl_r.run};
		end else if (s_axi_araddr_i == `PRPWM_INT_STAT_OFFS) begin
			rd_word[2:0] = int_stat_r;
		end else if (s_axi_araddr_i == `PRPWM_INT_MASK_OFFS) begin
			rd_word[2:0] = int_mask_r;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= `PRPWM_WORD_RST;
			s_axi_rresp_o  <= 2'h0;
		end else if (clk_en_i) begin
			if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= rd_word;
				s_axi_rresp_o  <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_r            <= '0;
			period_r          <= '0;
			tap_mask_reg_r    <= W'(`PRPWM_TAP_MASK_RST);
			compare_value_a_r <= '0;
			compare_value_b_r <= '0;
			int_mask_r        <= 3'h0;
		end else if (clk_en_i) begin
			if (wr_fire && wr_addr == `PRPWM_CTRL_OFFS) begin
				ctrl_r <= 4'(merge_word(32'(ctrl_r), wr_data, wr_strb));
			end else if (killed && ctrl_r.stop_on_kill) begin
				ctrl_r.run <= 1'b0;
			end
			if (wr_fire && wr_addr == `PRPWM_PERIOD_OFFS) begin
				period_r <= W'(merge_word(32'(period_r), wr_data, wr_strb));
			end
			if (wr_fire && wr_addr == `PRPWM_TAP_MASK_OFFS) begin
				tap_mask_reg_r <= W'(merge_word(32'(tap_mask_reg_r), wr_data, wr_strb));
			end
			if (wr_fire && wr_addr == `PRPWM_CMP_A_OFFS) begin
				compare_value_a_r <= W'(merge_word(32'(compare_value_a_r), wr_data, wr_strb));
			end
			if (wr_fire && wr_addr == `PRPWM_CMP_B_OFFS) begin
				compare_value_b_r <= W'(merge_word(32'(compare_value_b_r), wr_data, wr_strb));
			end
			if (wr_fire && wr_addr == `PRPWM_INT_MASK_OFFS) begin
				int_mask_r <= 3'(merge_word(32'(int_mask_r), wr_data, wr_strb));
			end
		end
	end

	// ==========================================================
	// LFSR counter
	assign killed   = kill_i || ctrl_r.sw_kill;
	assign step     = clk_en_i && count_tick_i && ctrl_r.run && !(killed && ctrl_r.stop_on_kill);
	// Masked XOR covers every documented tap set; zero stays zero, no lock-up escape
	assign feedback = ^(counter_r & tap_mask_reg_r);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			counter_r <= '0;
		end else if (clk_en_i) begin
			if (wr_fire && wr_addr == `PRPWM_COUNTER_OFFS) begin
				counter_r <= W'(merge_word(32'(counter_r), wr_data, wr_strb));
			end else if (step) begin
				counter_r <= {feedback, counter_r[W-1:1]};
			end
		end
	end

	// ==========================================================
	// Events and interrupts
	always_comb begin
		evt_nxt.terminal_count_event = step && (counter_r == period_r);
		evt_nxt.compare_a_hit        = step && (counter_r == compare_value_a_r);
		evt_nxt.compare_b_hit        = step && (counter_r == compare_value_b_r);
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			terminal_count_event_o <= 1'b0;
			compare_a_hit_o        <= 1'b0;
			compare_b_hit_o        <= 1'b0;
		end else if (clk_en_i) begin
			terminal_count_event_o <= evt_nxt.terminal_count_event;
			compare_a_hit_o        <= evt_nxt.compare_a_hit;
			compare_b_hit_o        <= evt_nxt.compare_b_hit;
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			int_stat_r <= 3'h0;
		end else if (clk_en_i) begin
			int_stat_r <= (int_stat_r & ~((wr_fire && wr_addr == `PRPWM_INT_STAT_OFFS) ? wr_data[2:0] : 3'h0))
				| {evt_nxt.compare_b_hit, evt_nxt.compare_a_hit, evt_nxt.terminal_count_event};
		end
	end

	assign irq_o = |(int_stat_r & int_mask_r);

	// ==========================================================
	// Line outputs
	assign line_raw = {1'b0, counter_r[W-2:0]} < compare_value_a_r;
	assign line_nxt = line_raw ^ ctrl_r.invert;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_wave_out_o    <= 1'b0;
			inverse_wave_out_o <= 1'b0;
		end else if (clk_en_i) begin
			line_wave_out_o    <= killed ? 1'b0 : line_nxt;
			inverse_wave_out_o <= killed ? 1'b0 : !line_nxt;
		end
	end

endmodule : pseudo_random_pwm_lfsr
`default_nettype wire

// ### verif/pseudo_random_pwm_lfsr_monitor.sv
// Port checker for the pseudo-random PWM block
`timescale 1ns/100ps
`default_nettype none
module prpwm_monitor (
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	input wire logic        clk_en_i,
	input wire logic        count_tick_i,
	input wire logic        kill_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        line_wave_out_o,
	input wire logic        inverse_wave_out_o,
	input wire logic        terminal_count_event_o,
	input wire logic        compare_a_hit_o
);
	// ====================
	// Properties
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_wr_taken;
		clk_en_i && s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_rd_taken;
		clk_en_i && s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid_o)
		else $error("write not answered");
	a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
		else $error("read not answered");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped");
	a_rd_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while pending");
	a_wave_pair: assert property (line_wave_out_o |-> !inverse_wave_out_o)
		else $error("both wave outputs high");
	a_kill_quiet: assert property (clk_en_i && kill_i |=> !line_wave_out_o && !inverse_wave_out_o)
		else $error("wave not suppressed");
	a_event_step: assert property (terminal_count_event_o || compare_a_hit_o |-> $past(count_tick_i) && $past(clk_en_i))
		else $error("event without step");
endmodule : prpwm_monitor
bind pseudo_random_pwm_lfsr prpwm_monitor u_mon (.core_clk_i, .rst_b_i, .clk_en_i, .count_tick_i, .kill_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .line_wave_out_o,
	.inverse_wave_out_o, .terminal_count_event_o, .compare_a_hit_o);
`default_nettype wire

// ### verif/tb_pseudo_random_pwm_lfsr.sv
// Self-checking bench for the pseudo-random PWM block
`timescale 1ns/100ps
`default_nettype none
`include "prpwm_regs.svh"
`define CHK(nm, x, g) begin num_checks++; if ((g) !== (x)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, x, g); end end
module tb_pseudo_random_pwm_lfsr;
	logic        core_clk_i = 1'b0, rst_b_i = 1'b0, clk_en_i = 1'b1, count_tick_i = 1'b0, kill_i = 1'b0;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, e;
	logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rnd = 32'h2d, rv, c, a;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, lr;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
	logic        line_wave_out_o, inverse_wave_out_o, terminal_count_event_o, compare_a_hit_o, compare_b_hit_o;
	logic [15:0] p, masks [5] = '{16'h1d00, 16'h3000, 16'h0880, 16'h0003, 16'h002d};
	int          errors = 0, num_checks = 0, n, seen;

	pseudo_random_pwm_lfsr #(.GROUP_COUNTER_WIDTH(16)) u_dut (.core_clk_i, .rst_b_i, .clk_en_i, .count_tick_i,
		.kill_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
		.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
		.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.line_wave_out_o, .inverse_wave_out_o, .terminal_count_event_o, .compare_a_hit_o, .compare_b_hit_o, .irq_o);

	always #50 core_clk_i = ~core_clk_i;

	// ====================
	// Models and bus tasks
	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction : xs
	function automatic logic [15:0] step(input logic [15:0] v, input logic [15:0] m);
		return {^(v & m), v[15:1]};
	endfunction : step
	function automatic int cyc(input logic [15:0] v, input logic [15:0] m);
		int k;
		logic [15:0] w;
		w = step(v, m);
		for (k = 1; w != v && k < 70000; k++) w = step(w, m);
		return k;
	endfunction : cyc
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		bit at = 1'b0, wt = 1'b0;
		s_axi_awaddr_i <= ad;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		// Random bready stall exercises response holding
		s_axi_bready_i <= 1'(xs());
		while (!(at && wt)) begin
			@(posedge core_clk_i);
			at |= s_axi_awvalid_i && s_axi_awready_o;
			wt |= s_axi_wvalid_i && s_axi_wready_o;
			if (at) s_axi_awvalid_i <= 1'b0;
			if (wt) s_axi_wvalid_i <= 1'b0;
		end
		do begin
			@(posedge core_clk_i);
			if (s_axi_bvalid_o && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
		end while (!(s_axi_bvalid_o && s_axi_bready_i));
		lr = s_axi_bresp_o;
	endtask : wr
	task automatic rdr(input logic [11:0] ad);
		s_axi_araddr_i <= ad;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'(xs());
		do @(posedge core_clk_i); while (!(s_axi_arvalid_i && s_axi_arready_o));
		s_axi_arvalid_i <= 1'b0;
		do begin
			@(posedge core_clk_i);
			if (s_axi_rvalid_o && !s_axi_rready_i) s_axi_rready_i <= 1'b1;
		end while (!(s_axi_rvalid_o && s_axi_rready_i));
		rv = s_axi_rdata_o;
		lr = s_axi_rresp_o;
	endtask : rdr
	task automatic tick(input int k);
		count_tick_i <= 1'b1;
		repeat (k) @(posedge core_clk_i);
		count_tick_i <= 1'b0;
	endtask : tick
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	initial begin
		// Longest test is the 65535-step cycle
		#(100000 * 100);
		errors++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		rdr(`PRPWM_TAP_MASK_OFFS);
		`CHK("tap mask", `PRPWM_TAP_MASK_RST, rv)
		rdr(12'h100);
		`CHK("bad read", 34'h2_0000_0000, {lr, rv})
		wr(12'h100, 32'h1);
		`CHK("bad write", 2'h2, lr)
		$display("reset test done");
		wr(`PRPWM_CTRL_OFFS, 32'h1);
		wr(`PRPWM_COUNTER_OFFS, 32'h0);
		tick(4);
		rdr(`PRPWM_COUNTER_OFFS);
		`CHK("zero stays", 32'h0, rv)
		wr(`PRPWM_COUNTER_OFFS, 32'hace1);
		clk_en_i <= 1'b0;
		tick(3);
		clk_en_i <= 1'b1;
		rdr(`PRPWM_COUNTER_OFFS);
		`CHK("frozen", 16'hace1, rv[15:0])
		$display("hold test done");
		foreach (masks[k]) begin
			// Period taken 20 steps in, so the state is already on its cycle
			p = 16'hace1;
			repeat (20) p = step(p, masks[k]);
			wr(`PRPWM_CTRL_OFFS, 32'h0);
			wr(`PRPWM_TAP_MASK_OFFS, {16'h0, masks[k]});
			wr(`PRPWM_PERIOD_OFFS, {16'h0, p});
			wr(`PRPWM_COUNTER_OFFS, 32'hace1);
			wr(`PRPWM_CTRL_OFFS, 32'h1);
			count_tick_i <= 1'b1;
			n = 0;
			seen = 0;
			while (seen < 2 && n < 70000) begin
				@(posedge core_clk_i);
				if (seen == 1) n++;
				if (terminal_count_event_o) seen++;
			end
			count_tick_i <= 1'b0;
			`CHK("cycle", cyc(p, masks[k]), n)
		end
		$display("cycle test done");
		wr(`PRPWM_INT_STAT_OFFS, 32'h7);
		wr(`PRPWM_PERIOD_OFFS, 32'h0);
		c = xs() | 32'h1;
		wr(`PRPWM_COUNTER_OFFS, {16'h0, c[15:0]});
		wr(`PRPWM_CMP_A_OFFS, {16'h0, c[15:0]});
		wr(`PRPWM_CMP_B_OFFS, {16'h0, c[15:0]});
		tick(1);
		@(posedge core_clk_i);
		`CHK("hits", 2'h3, {compare_b_hit_o, compare_a_hit_o})
		rdr(`PRPWM_INT_STAT_OFFS);
		`CHK("int status", 32'h6, rv)
		`CHK("irq masked", 1'b0, irq_o)
		wr(`PRPWM_INT_MASK_OFFS, 32'h2);
		`CHK("irq set", 1'b1, irq_o)
		wr(`PRPWM_INT_STAT_OFFS, 32'h2);
		`CHK("irq clear", 1'b0, irq_o)
		$display("event test done");
		for (int i = 0; i < 12; i++) begin
			c = (i == 1) ? 32'h7fff : xs();
			a = (i < 2) ? 32'h8000 - i : xs();
			wr(`PRPWM_CTRL_OFFS, {29'h0, c[20], 2'h0});
			wr(`PRPWM_COUNTER_OFFS, {16'h0, c[15:0]});
			wr(`PRPWM_CMP_A_OFFS, {16'h0, a[15:0]});
			repeat (2) @(posedge core_clk_i);
			e = ({1'b0, c[14:0]} < a[15:0]) ^ c[20];
			`CHK("line", e, line_wave_out_o)
			`CHK("inverse", !e, inverse_wave_out_o)
		end
		// Software kill bit must silence both lines and show in status
		wr(`PRPWM_CTRL_OFFS, 32'h8);
		@(posedge core_clk_i);
		`CHK("sw kill", 2'h0, {line_wave_out_o, inverse_wave_out_o})
		rdr(`PRPWM_STATUS_OFFS);
		`CHK("status", 32'h4, rv)
		$display("compare test done");
		wr(`PRPWM_COUNTER_OFFS, 32'hace1);
		wr(`PRPWM_CTRL_OFFS, 32'h1);
		kill_i <= 1'b1;
		tick(5);
		kill_i <= 1'b0;
		p = 16'hace1;
		repeat (5) p = step(p, 16'h002d);
		rdr(`PRPWM_COUNTER_OFFS);
		`CHK("kill runs", p, rv[15:0])
		wr(`PRPWM_CTRL_OFFS, 32'h3);
		kill_i <= 1'b1;
		@(posedge core_clk_i);
		kill_i <= 1'b0;
		tick(5);
		rdr(`PRPWM_COUNTER_OFFS);
		`CHK("kill stops", p, rv[15:0])
		rdr(`PRPWM_CTRL_OFFS);
		`CHK("run cleared", 1'b0, rv[0])
		$display("kill test done");
		conclude();
	end
endmodule : tb_pseudo_random_pwm_lfsr
`default_nettype wire
